// ===== shared/cfg_bank_defs.vh
// Purpose: Offsets, field positions, reset values, writable masks and segment numbers for the chipset config bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Indices are printed as bytes; byte address is four times the index
`ifndef CFG_BANK_DEFS_VH
`define CFG_BANK_DEFS_VH

// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define IDX_POWER_MISC_CONTROL 8'h2C
`define IDX_SCRATCH_A 8'h2D
`define IDX_SCRATCH_B 8'h2E
`define IDX_MEMORY_SEGMENT_MAPPING 8'h2F
`define IDX_LOCAL_IDE_CONTROL 8'h30
`define IDX_LOCAL_IDE_TIMING 8'h31
`define IDX_IDE_MODE 8'h32
`define ADDR_W 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_POWER_MISC_CONTROL 8'h00
`define RST_SCRATCH 8'h00
`define RST_MEMORY_SEGMENT_MAPPING 8'h00
`define RST_LOCAL_IDE_CONTROL 8'h00
`define RST_LOCAL_IDE_TIMING 8'h11
`define RST_IDE_MODE 8'h10
// Synchroniser idle word: processor ready is active low, so its bit rests high
`define RST_PIN_SYNC 12'h400

// ----------------------------------------
// Writable masks (reserved bits read zero)
// ----------------------------------------
`define WMASK_POWER_MISC_CONTROL 8'h7E
`define WMASK_MEMORY_SEGMENT_MAPPING 8'hF2
`define WMASK_IDE_MODE 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_HOLD_ON_STOP 6
`define PMC_FLUSH_ON_READY 5
`define PMC_SELECTED_CLOCK_SOURCE_STOP 4
`define PMC_LEAKAGE_CTL 3
`define PMC_MODULE_GATE 2
`define PMC_EXPBUS_STOP 1
`define MAP_REMAP 7
`define MAP_D_SMM 6
`define MAP_C_SMM 5
`define MAP_D8_ROM 4
`define MAP_D_LOCAL 1
`define MAP_C_LOCAL 0
`define IDE_ALE_EN 3
`define IDE_WIDE32 2
`define IDE_DRIVE1 1
`define IDE_DRIVE0 0
`define MODE_SPLIT 4

// ----------------------------------------
// Segment numbers (address bits 19:16 of a 64 KiB-granular segment)
// ----------------------------------------
`define SEG_3000 4'h3
`define SEG_6000 4'h6
`define SEG_A000 4'hA
`define SEG_B000 4'hB
`define SEG_C000 4'hC
`define SEG_D000 4'hD
`define SEG_F000 4'hF

`endif

// ===== verilog/segment_decode.v
// Purpose: Decodes a 20-bit memory address against the segment mapping register
// Assumes: Pure combinational, same clock domain as the caller
// Notes: Caller registers all results
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_defs.vh"

module segment_decode (
	// Mapping control
	input wire [7:0] map_i,
	// Address
	input wire [19:0] addr_i,
	// Decode results
	output reg [19:0] remap_o,
	output reg smm_o,
	output reg rom_o,
	output reg local_ram_o
);

	wire [3:0] seg = addr_i[19:16];

	always @* begin
		remap_o = addr_i;
		if (map_i[`MAP_REMAP]) begin
			if (seg == `SEG_3000 || seg == `SEG_D000 || seg == `SEG_F000) begin
				remap_o = {`SEG_B000, addr_i[15:0]}; // RL8
			end else if (seg == `SEG_6000 || seg == `SEG_C000) begin
				remap_o = {`SEG_A000, addr_i[15:0]}; // RL8
			end
		end
		smm_o = (map_i[`MAP_D_SMM] && seg == `SEG_D000) || (map_i[`MAP_C_SMM] && seg == `SEG_C000); // RL9 RL10
		rom_o = map_i[`MAP_D8_ROM] && seg == `SEG_D000 && addr_i[15]; // RL11
		local_ram_o = (map_i[`MAP_D_LOCAL] && seg == `SEG_D000) || (map_i[`MAP_C_LOCAL] && seg == `SEG_C000); // RL12 RL13
	end

endmodule
`default_nettype wire

// ===== verilog/chipset_config_regs.v
// Purpose: Power, scratch, segment mapping and local IDE configuration bank behind APB
// Assumes: Single 100 MHz core clock; pin inputs are synchronised here
// Notes: Pin-driven outputs lag their pins by three edges, except local RAM, which lags its strap by four; decode outputs lag the address by one
// Function
// RL1 - Power bit 6 makes hold request follow stop-clock request.
// RL2 - Power bit 5 at normal speed makes flush follow processor ready.
// RL3 - Power bit 4 stops the selected clock source during suspend.
// RL4 - Power bit 3 enables pin leakage control only during suspend.
// RL5 - Power bit 2 gates clocks of idle internal modules.
// RL6 - Power bit 1 stops expansion-bus module when no expansion cycle runs.
// RL7 - Two scratch registers at indices 2Dh and 2Eh.
// RL8 - Mapping bit 7 redirects management segments to B000h or A000h.
// RL9 - Mapping bit 6 makes D0000h-DFFFFh management space.
// RL10 - Mapping bit 5 makes C0000h-CFFFFh management space.
// RL11 - Mapping bit 4 puts D8000h-DFFFFh in ROM BIOS space.
// RL12 - Mapping bit 1 routes D0000h-DFFFFh to local RAM.
// RL13 - Mapping bit 0 is read-only; one means C segment is local RAM.
// RL14 - Read width field bits 7-4 gives value plus one, 1 to 16.
// RL15 - IDE bit 3 drives address latch enable during local IDE cycles.
// RL16 - IDE bit 2 allows 32-bit cycles, else 16-bit only.
// RL17 - IDE bit 1 routes drive 1 accesses to the local bus.
// RL18 - IDE bit 0 routes drive 0 accesses to the local bus.
// RL19 - Recovery field bits 7-4 gives value plus one; default one.
// RL20 - Write width field bits 3-0 gives value plus one; default one.
// RL21 - Split bit zero uses write width for both; one separates them.
// RL22 - Scratch registers read back last write and steer nothing.
// RL23 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_defs.vh"

module chipset_config_regs (
	// Clock and reset
	input wire core_clk_i,
	input wire rst_b_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [`ADDR_W-1:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [3:0] pstrb_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// Processor and system pins
	input wire stop_clock_request_i,
	input wire processor_ready_b_i,
	input wire turbo_speed_i,
	input wire suspend_i,
	input wire c_segment_local_strap_i,
	input wire expansion_cycle_active_i,
	input wire [3:0] module_in_use_i,
	output reg hold_request_o,
	output reg cache_flush_b_o,
	output reg selected_clock_source_en_o,
	output reg leakage_control_en_o,
	output reg [3:0] module_clock_en_o,
	output reg expansion_module_run_o,
	// Memory decode
	input wire [19:0] mem_addr_i,
	output reg [19:0] mem_addr_remap_o,
	output reg system_management_space_o,
	output reg rom_bios_space_o,
	output reg local_ram_space_o,
	// Local IDE cycle setup
	input wire ide_cycle_active_i,
	input wire ide_drive_sel_i,
	output reg address_latch_enable_o,
	output reg ide_wide32_en_o,
	output reg ide_local_route_o,
	output reg [4:0] ide_read_width_o,
	output reg [4:0] ide_write_width_o,
	output reg [4:0] ide_recovery_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam SYNC_W = 12;
	wire [SYNC_W-1:0] pin_raw = {stop_clock_request_i, processor_ready_b_i, turbo_speed_i, suspend_i,
		c_segment_local_strap_i, expansion_cycle_active_i, module_in_use_i, ide_cycle_active_i, ide_drive_sel_i};
	reg [SYNC_W-1:0] sync1_r;
	reg [SYNC_W-1:0] sync2_r;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// Idle levels, so a quiet pin shows no false event just after reset
			sync1_r <= `RST_PIN_SYNC;
			sync2_r <= `RST_PIN_SYNC;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	wire stop_clk_s = sync2_r[11];
	wire cpu_ready_s = ~sync2_r[10];
	wire turbo_s = sync2_r[9];
	wire suspend_s = sync2_r[8];
	wire c_local_s = sync2_r[7];
	wire exp_active_s = sync2_r[6];
	wire [3:0] in_use_s = sync2_r[5:2];
	wire ide_active_s = sync2_r[1];
	wire drive_sel_s = sync2_r[0];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	reg [7:0] power_misc_control_r;
	reg [7:0] scratch_a_r;
	reg [7:0] scratch_b_r;
	reg [7:0] memory_segment_mapping_r;
	reg [7:0] local_ide_control_r;
	reg [7:0] local_ide_timing_r;
	reg [7:0] ide_mode_r;
	reg c_local_r;

	wire [7:0] reg_idx = paddr_i[9:2];
	wire word_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[`ADDR_W-1:10] == 2'h0);
	wire hit = word_ok && (reg_idx >= `IDX_POWER_MISC_CONTROL) && (reg_idx <= `IDX_IDE_MODE);
	// The first access cycle is a wait state; pready rises in the second
	wire access = psel_i && penable_i && !pready_o;
	// A write lands at the edge where the master samples pready high, never earlier
	wire commit = psel_i && penable_i && pready_o;
	wire wr_en = commit && pwrite_i && hit && pstrb_i[0];
	wire wr_power = wr_en && (reg_idx == `IDX_POWER_MISC_CONTROL);
	wire wr_scratch_a = wr_en && (reg_idx == `IDX_SCRATCH_A);
	wire wr_scratch_b = wr_en && (reg_idx == `IDX_SCRATCH_B);
	wire wr_mapping = wr_en && (reg_idx == `IDX_MEMORY_SEGMENT_MAPPING);
	wire wr_ide_control = wr_en && (reg_idx == `IDX_LOCAL_IDE_CONTROL);
	wire wr_ide_timing = wr_en && (reg_idx == `IDX_LOCAL_IDE_TIMING);
	wire wr_ide_mode = wr_en && (reg_idx == `IDX_IDE_MODE);

	// Merges only writable bits, keeping reserved ones at zero
	function [7:0] merge;
		input [7:0] old;
		input [7:0] din;
		input [7:0] wmask;
		begin
			merge = (din & wmask) | (old & ~wmask);
		end
	endfunction

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_misc_control_r <= `RST_POWER_MISC_CONTROL;
		end else if (wr_power) begin
			power_misc_control_r <= merge(power_misc_control_r, pwdata_i[7:0], `WMASK_POWER_MISC_CONTROL); // RL23
		end
	end

	// Scratch bytes steer nothing; they only hold what software left there
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scratch_a_r <= `RST_SCRATCH;
		end else if (wr_scratch_a) begin
			scratch_a_r <= pwdata_i[7:0]; // RL7 RL22
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scratch_b_r <= `RST_SCRATCH;
		end else if (wr_scratch_b) begin
			scratch_b_r <= pwdata_i[7:0]; // RL7 RL22
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			memory_segment_mapping_r <= `RST_MEMORY_SEGMENT_MAPPING;
		end else if (wr_mapping) begin
			memory_segment_mapping_r <= merge(memory_segment_mapping_r, pwdata_i[7:0],
				`WMASK_MEMORY_SEGMENT_MAPPING); // RL13 RL23
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_ide_control_r <= `RST_LOCAL_IDE_CONTROL;
		end else if (wr_ide_control) begin
			local_ide_control_r <= pwdata_i[7:0]; // RL14 RL15 RL16 RL17 RL18
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			local_ide_timing_r <= `RST_LOCAL_IDE_TIMING;
		end else if (wr_ide_timing) begin
			local_ide_timing_r <= pwdata_i[7:0]; // RL19 RL20
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ide_mode_r <= `RST_IDE_MODE;
		end else if (wr_ide_mode) begin
			ide_mode_r <= merge(ide_mode_r, pwdata_i[7:0], `WMASK_IDE_MODE); // RL21 RL23
		end
	end

	// Read-only local RAM flag follows the synchronised strap pin on every edge after reset
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c_local_r <= 1'b0;
		end else begin
			c_local_r <= c_local_s; // RL13
		end
	end

	wire [7:0] map_eff = {memory_segment_mapping_r[7:1], c_local_r};

	reg [7:0] rd_byte;
	always @* begin
		case (reg_idx)
			`IDX_POWER_MISC_CONTROL: rd_byte = power_misc_control_r;
			`IDX_SCRATCH_A: rd_byte = scratch_a_r;
			`IDX_SCRATCH_B: rd_byte = scratch_b_r;
			`IDX_MEMORY_SEGMENT_MAPPING: rd_byte = map_eff;
			`IDX_LOCAL_IDE_CONTROL: rd_byte = local_ide_control_r;
			`IDX_LOCAL_IDE_TIMING: rd_byte = local_ide_timing_r;
			`IDX_IDE_MODE: rd_byte = ide_mode_r;
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// APB response
	// ----------------------------------------
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else if (access) begin
			pready_o <= 1'b1;
			pslverr_o <= !hit;
			prdata_o <= (hit && !pwrite_i) ? {24'h000000, rd_byte} : 32'h00000000; // RL23
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// Power control
	// ----------------------------------------
	// With gating off every module clock keeps running
	wire [3:0] module_clk_nxt;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_module_gate
			assign module_clk_nxt[g] = !power_misc_control_r[`PMC_MODULE_GATE] || in_use_s[g]; // RL5
		end
	endgenerate

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_request_o <= 1'b0;
			cache_flush_b_o <= 1'b1;
			selected_clock_source_en_o <= 1'b1;
			leakage_control_en_o <= 1'b0;
			module_clock_en_o <= 4'hF;
			expansion_module_run_o <= 1'b1;
		end else begin
			hold_request_o <= power_misc_control_r[`PMC_HOLD_ON_STOP] && stop_clk_s; // RL1
			cache_flush_b_o <= !(power_misc_control_r[`PMC_FLUSH_ON_READY] && !turbo_s && cpu_ready_s); // RL2
			selected_clock_source_en_o <= !(power_misc_control_r[`PMC_SELECTED_CLOCK_SOURCE_STOP] && suspend_s); // RL3
			leakage_control_en_o <= power_misc_control_r[`PMC_LEAKAGE_CTL] && suspend_s; // RL4
			module_clock_en_o <= module_clk_nxt; // RL5
			expansion_module_run_o <= !power_misc_control_r[`PMC_EXPBUS_STOP] || exp_active_s; // RL6
		end
	end

	// ----------------------------------------
	// Memory segment decode
	// ----------------------------------------
	wire [19:0] remap_w;
	wire smm_w;
	wire rom_w;
	wire local_w;

	// Address is taken from logic on this clock, so it is not synchronised
	segment_decode u_segment_decode (
		.map_i(map_eff),
		.addr_i(mem_addr_i),
		.remap_o(remap_w),
		.smm_o(smm_w),
		.rom_o(rom_w),
		.local_ram_o(local_w)
	);

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_addr_remap_o <= 20'h00000;
			system_management_space_o <= 1'b0;
			rom_bios_space_o <= 1'b0;
			local_ram_space_o <= 1'b0;
		end else begin
			mem_addr_remap_o <= remap_w; // RL8
			system_management_space_o <= smm_w; // RL9 RL10
			rom_bios_space_o <= rom_w; // RL11
			local_ram_space_o <= local_w; // RL12 RL13
		end
	end

	// ----------------------------------------
	// Local IDE setup
	// ----------------------------------------
	wire split = ide_mode_r[`MODE_SPLIT];
	wire [3:0] rd_field = split ? local_ide_control_r[7:4] : local_ide_timing_r[3:0];
	// Route follows the drive now addressed; each drive has its own enable
	wire route_nxt = drive_sel_s ? local_ide_control_r[`IDE_DRIVE1] : local_ide_control_r[`IDE_DRIVE0]; // RL17 RL18
	// Widths and recovery count from one, so a zero field still gives one cycle
	wire [4:0] rd_width_nxt = {1'b0, rd_field} + 5'h01; // RL14 RL21
	wire [4:0] wr_width_nxt = {1'b0, local_ide_timing_r[3:0]} + 5'h01; // RL20
	wire [4:0] recovery_nxt = {1'b0, local_ide_timing_r[7:4]} + 5'h01; // RL19

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			address_latch_enable_o <= 1'b0;
			ide_wide32_en_o <= 1'b0;
			ide_local_route_o <= 1'b0;
			ide_read_width_o <= 5'h02;
			ide_write_width_o <= 5'h02;
			ide_recovery_o <= 5'h02;
		end else begin
			address_latch_enable_o <= local_ide_control_r[`IDE_ALE_EN] && ide_active_s; // RL15
			ide_wide32_en_o <= local_ide_control_r[`IDE_WIDE32]; // RL16
			ide_local_route_o <= route_nxt; // RL17 RL18
			ide_read_width_o <= rd_width_nxt; // RL14 RL21
			ide_write_width_o <= wr_width_nxt; // RL20
			ide_recovery_o <= recovery_nxt; // RL19
		end
	end

endmodule
`default_nettype wire

// ===== tb/cfg_regs_checker_sva.sv
// Purpose: Port-level temporal checks for the chipset config bank
// Assumes: Pin outputs lag pins by three edges; APB answers one cycle after the access is taken
// Notes: Pins must stay inactive through reset so that the first three lookbacks are harmless
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_checker (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	// Pins in
	input wire logic stop_clock_request_i,
	input wire logic processor_ready_b_i,
	input wire logic turbo_speed_i,
	input wire logic suspend_i,
	input wire logic expansion_cycle_active_i,
	input wire logic [3:0] module_in_use_i,
	input wire logic ide_cycle_active_i,
	input wire logic [19:0] mem_addr_i,
	// Pins out
	input wire logic hold_request_o,
	input wire logic cache_flush_b_o,
	input wire logic selected_clock_source_en_o,
	input wire logic leakage_control_en_o,
	input wire logic [3:0] module_clock_en_o,
	input wire logic expansion_module_run_o,
	input wire logic address_latch_enable_o,
	input wire logic local_ram_space_o
);
	logic [3:0] seg_w;
	assign seg_w = mem_addr_i[19:16];
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_hold; hold_request_o |-> $past(stop_clock_request_i, 3); endproperty
	a_hold: assert property (p_hold) else $error("hold without stop request");
	property p_flush; !cache_flush_b_o |-> !$past(processor_ready_b_i, 3) && !$past(turbo_speed_i, 3); endproperty
	a_flush: assert property (p_flush) else $error("flush without ready at normal speed");
	property p_clk; !selected_clock_source_en_o |-> $past(suspend_i, 3); endproperty
	a_clk: assert property (p_clk) else $error("clock source stopped outside suspend");
	property p_leak; leakage_control_en_o |-> $past(suspend_i, 3); endproperty
	a_leak: assert property (p_leak) else $error("leakage control outside suspend");
	property p_mod; (module_clock_en_o | ~$past(module_in_use_i, 3)) == 4'hF; endproperty
	a_mod: assert property (p_mod) else $error("busy module lost its clock");
	property p_exp; !expansion_module_run_o |-> !$past(expansion_cycle_active_i, 3); endproperty
	a_exp: assert property (p_exp) else $error("expansion module stopped mid cycle");
	property p_ale; address_latch_enable_o |-> $past(ide_cycle_active_i, 3); endproperty
	a_ale: assert property (p_ale) else $error("latch enable outside ide cycle");
	property p_ready; psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o; endproperty
	a_ready: assert property (p_ready) else $error("ready not a one cycle answer");
	property p_lram; local_ram_space_o |-> $past(seg_w) inside {4'hC, 4'hD}; endproperty
	a_lram: assert property (p_lram) else $error("local ram outside C or D segment");
	c_hold: cover property (hold_request_o);
	c_flush: cover property (!cache_flush_b_o);
	c_lram: cover property (local_ram_space_o);
endmodule
`default_nettype wire

// ===== tb/pin_partner.sv
// Purpose: Processor and drive side pins, launched one edge after the bench asks
// Assumes: Bench supplies a stimulus word on the core clock
// Notes: Ready is held inactive high in reset so the bank sees a quiet processor
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
	// Clock, reset and stimulus
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] knob_i,
	// Processor and drive side
	output logic stop_clock_request_o,
	output logic processor_ready_b_o,
	output logic turbo_speed_o,
	output logic suspend_o,
	output logic expansion_cycle_active_o,
	output logic [3:0] module_in_use_o,
	output logic ide_cycle_active_o,
	output logic ide_drive_sel_o
);
	// ----------------------------------------
	// Pin launch
	// ----------------------------------------
	logic [11:0] pins_r;
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			pins_r <= 12'h002;
		else
			pins_r <= knob_i;
	end
	assign stop_clock_request_o = pins_r[0];
	assign processor_ready_b_o = pins_r[1];
	assign turbo_speed_o = pins_r[2];
	assign suspend_o = pins_r[3];
	assign expansion_cycle_active_o = pins_r[5];
	assign module_in_use_o = pins_r[9:6];
	assign ide_cycle_active_o = pins_r[10];
	assign ide_drive_sel_o = pins_r[11];
endmodule
`default_nettype wire

// ===== tb/chipset_config_regs_ide_power_tb_top.sv
// Purpose: Self-checking bench for the chipset config bank against a register model
// Assumes: Byte address is four times the index; pins settle six edges after a change
// Notes: Every register is written with random data and strobes, then all outputs are compared
`timescale 1ns/1ps
`default_nettype none
module chipset_config_regs_ide_power_tb_top;
	logic core_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [11:0] paddr_i, knob;
	logic [31:0] pwdata_i, prdata_o, rd, d;
	logic [3:0] pstrb_i, module_in_use_i, module_clock_en_o, s, sg;
	logic stop_clock_request_i, processor_ready_b_i, turbo_speed_i, suspend_i, c_segment_local_strap_i;
	logic expansion_cycle_active_i, ide_cycle_active_i, ide_drive_sel_i, hold_request_o, cache_flush_b_o;
	logic selected_clock_source_en_o, leakage_control_en_o, expansion_module_run_o;
	logic [19:0] mem_addr_i, mem_addr_remap_o;
	logic system_management_space_o, rom_bios_space_o, local_ram_space_o;
	logic address_latch_enable_o, ide_wide32_en_o, ide_local_route_o;
	logic [4:0] ide_read_width_o, ide_write_width_o, ide_recovery_o;
	logic [7:0] m [0:6];
	logic [7:0] wm [0:6];
	logic [3:0] segs [0:5];
	int err_total = 0, tests_run = 0, cyc = 0, seed, i, r;

	chipset_config_regs dut (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i, .prdata_o, .pready_o, .pslverr_o, .stop_clock_request_i, .processor_ready_b_i, .turbo_speed_i,
		.suspend_i, .c_segment_local_strap_i, .expansion_cycle_active_i, .module_in_use_i, .hold_request_o,
		.cache_flush_b_o, .selected_clock_source_en_o, .leakage_control_en_o, .module_clock_en_o,
		.expansion_module_run_o, .mem_addr_i, .mem_addr_remap_o, .system_management_space_o, .rom_bios_space_o,
		.local_ram_space_o, .ide_cycle_active_i, .ide_drive_sel_i, .address_latch_enable_o, .ide_wide32_en_o,
		.ide_local_route_o, .ide_read_width_o, .ide_write_width_o, .ide_recovery_o);
	pin_partner u_pins (.core_clk_i, .rst_b_i, .knob_i(knob), .stop_clock_request_o(stop_clock_request_i),
		.processor_ready_b_o(processor_ready_b_i), .turbo_speed_o(turbo_speed_i), .suspend_o(suspend_i),
		.expansion_cycle_active_o(expansion_cycle_active_i), .module_in_use_o(module_in_use_i),
		.ide_cycle_active_o(ide_cycle_active_i), .ide_drive_sel_o(ide_drive_sel_i));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		pstrb_i <= st;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		// Waits as long as the slave needs; only the hang guard ends a stall
		do begin
			@(posedge core_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic outs;
		logic [7:0] p, mp, c, t;
		logic [3:0] ns;
		p = m[0];
		mp = m[3];
		c = m[4];
		t = m[5];
		ns = (mp[7] && (sg == 4'h3 || sg == 4'hD || sg == 4'hF)) ? 4'hB :
			(mp[7] && (sg == 4'h6 || sg == 4'hC)) ? 4'hA : sg;
		chk(hold_request_o, p[6] & knob[0]);
		chk(cache_flush_b_o, !(p[5] & !knob[2] & !knob[1]));
		chk(selected_clock_source_en_o, !(p[4] & knob[3]));
		chk(leakage_control_en_o, p[3] & knob[3]);
		chk(module_clock_en_o, p[2] ? knob[9:6] : 4'hF);
		chk(expansion_module_run_o, !p[1] | knob[5]);
		chk(address_latch_enable_o, c[3] & knob[10]);
		chk(ide_wide32_en_o, c[2]);
		chk(ide_local_route_o, knob[11] ? c[1] : c[0]);
		chk(ide_read_width_o, m[6][4] ? c[7:4] + 1 : t[3:0] + 1);
		chk(ide_write_width_o, t[3:0] + 1);
		chk(ide_recovery_o, t[7:4] + 1);
		chk(mem_addr_remap_o, {ns, mem_addr_i[15:0]});
		chk(system_management_space_o, (sg == 4'hD & mp[6]) | (sg == 4'hC & mp[5]));
		chk(local_ram_space_o, (sg == 4'hD & mp[1]) | (sg == 4'hC & c_segment_local_strap_i));
		chk(rom_bios_space_o, (sg == 4'hD) & mp[4] & mem_addr_i[15]);
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	// Hang guard
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			test_done;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h8B1D4CFD;
		rst_b_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		pstrb_i = 4'h0;
		knob = 12'h002;
		mem_addr_i = 20'h00000;
		sg = 4'h0;
		c_segment_local_strap_i = 1'b0;
		m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h10};
		wm = '{8'h7E, 8'hFF, 8'hFF, 8'hF2, 8'hFF, 8'hFF, 8'h10};
		segs = '{4'h3, 4'h6, 4'hC, 4'hD, 4'hF, 4'hA};
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		for (i = 0; i < 7; i++) begin
			apb(1'b0, 12'hB0 + 12'(i * 4), 32'h0, 4'h0);
			chk(rd, {24'h0, m[i]});
		end
		apb(1'b0, 12'hCC, 32'h0, 4'h0);
		chk({31'h0, err}, 32'h1);
		outs;
		$display("reset test done");
		for (r = 0; r < 42; r++) begin
			i = r % 7;
			d = $random(seed);
			s = 4'($random(seed));
			apb(1'b1, 12'hB0 + 12'(i * 4), d, s);
			if (s[0])
				m[i] = (m[i] & ~wm[i]) | (d[7:0] & wm[i]);
			sg = segs[{$random(seed)} % 6];
			knob <= 12'($random(seed));
			c_segment_local_strap_i <= 1'($random(seed));
			mem_addr_i <= {sg, 16'($random(seed))};
			repeat (6) @(posedge core_clk_i);
			apb(1'b0, 12'hB0 + 12'(i * 4), 32'h0, 4'h0);
			chk(rd, {24'h0, (i == 3) ? {m[3][7:1], c_segment_local_strap_i} : m[i]});
			outs;
		end
		$display("random test done");
		test_done;
	end
endmodule

bind chipset_config_regs cfg_regs_checker u_chk (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o,
	.stop_clock_request_i, .processor_ready_b_i, .turbo_speed_i, .suspend_i, .expansion_cycle_active_i,
	.module_in_use_i, .ide_cycle_active_i, .mem_addr_i, .hold_request_o, .cache_flush_b_o,
	.selected_clock_source_en_o, .leakage_control_en_o, .module_clock_en_o, .expansion_module_run_o,
	.address_latch_enable_o, .local_ram_space_o);
`default_nettype wire
